// >>> verilog/collision_jabber_control.v
// Collision signalling, heartbeat and jabber protection of a coax transceiver.
// Assumes squelch and comparator decisions arrive as synchronous digital levels.
`timescale 1ns/1ps
`default_nettype none
`include "coll_jab_defines.vh"

module collision_jabber_control #(
    parameter JAB_TICKS = `CJ_JAB_TICKS,
    parameter UNJAB_TICKS = `CJ_UNJAB_TICKS,
    parameter FIFO_DEPTH = `CJ_FIFO_DEPTH
) (
    // Clock and reset
    input wire CLK_I,
    input wire RST_N_I,
    // Terminal side transmit input
    input wire TX_DATA_I,
    input wire TX_SQUELCH_OK_I,
    // Coax side
    input wire COAX_RECEIVE_IN_I,
    input wire RX_SQUELCH_OK_I,
    input wire COLLISION_CMP_I,
    input wire HEARTBEAT_GATE_N_I,
    // Coax drive out
    output reg COAX_DRIVE_OUT_O,
    output reg COAX_DRIVE_EN_O,
    // Terminal side outputs
    output reg RX_DATA_O,
    output reg RX_ACTIVE_O,
    output reg COLLISION_OUT_PAIR_P_O,
    output reg COLLISION_OUT_PAIR_N_O,
    output reg JABBER_O
);

    localparam TW = 32;
    localparam ST_IDLE = 2'd0;
    localparam ST_TX = 2'd1;
    localparam ST_JAB = 2'd2;
    localparam ST_UNJAB = 2'd3;

    reg [3:0] div_r;
    reg osc_r;
    reg tick_r;
    reg [1:0] st_r;
    reg [TW-1:0] jab_cnt_r;
    reg [3:0] idle_cnt_r;
    reg tx_seen_r;
    reg [4:0] hb_cnt_r;
    reg hb_wait_r;
    reg hb_on_r;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_data;
    wire tx_ok;
    wire any_cond;

    // ----------------------------------------
    // 10 MHz timebase
    // ----------------------------------------
    // Free-running divider
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            div_r <= 4'h0;
            osc_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (div_r == `CJ_OSC_HALF - 1) begin
                div_r <= 4'h0;
                osc_r <= ~osc_r;
                tick_r <= osc_r;
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Transmit activity and jabber
    // ----------------------------------------
    // Squelch qualification gates activity
    assign tx_ok = TX_SQUELCH_OK_I;

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            st_r <= ST_IDLE;
            jab_cnt_r <= {TW{1'b0}};
            idle_cnt_r <= 4'h0;
            tx_seen_r <= 1'b0;
        end else begin
            tx_seen_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    jab_cnt_r <= {TW{1'b0}};
                    idle_cnt_r <= 4'h0;
                    if (tx_ok) begin
                        st_r <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (tx_ok) begin
                        idle_cnt_r <= 4'h0;
                    end else if (tick_r) begin
                        idle_cnt_r <= idle_cnt_r + 4'h1;
                    end
                    if (tick_r) begin
                        jab_cnt_r <= jab_cnt_r + 1'b1;
                    end
                    // End after idle over 300 ns
                    if (!tx_ok && tick_r && idle_cnt_r == `CJ_TX_OFF_TICKS) begin
                        st_r <= ST_IDLE;
                        tx_seen_r <= 1'b1;
                    end else if (tick_r && jab_cnt_r == JAB_TICKS - 1) begin
                        st_r <= ST_JAB;
                    end
                end
                ST_JAB: begin
                    jab_cnt_r <= {TW{1'b0}};
                    if (!tx_ok) begin
                        st_r <= ST_UNJAB;
                    end
                end
                ST_UNJAB: begin
                    if (tx_ok) begin
                        st_r <= ST_JAB;
                    end else if (tick_r) begin
                        jab_cnt_r <= jab_cnt_r + 1'b1;
                        if (jab_cnt_r == UNJAB_TICKS - 1) begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Heartbeat
    // ----------------------------------------
    // Delay then burst, counted in ticks
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            hb_cnt_r <= 5'h00;
            hb_wait_r <= 1'b0;
            hb_on_r <= 1'b0;
        end else if (tx_seen_r && !HEARTBEAT_GATE_N_I) begin
            hb_wait_r <= 1'b1;
            hb_on_r <= 1'b0;
            hb_cnt_r <= 5'h00;
        end else if (tick_r && (hb_wait_r || hb_on_r)) begin
            if (hb_wait_r && hb_cnt_r == `CJ_HB_DELAY_TICKS - 1) begin
                hb_wait_r <= 1'b0;
                hb_on_r <= 1'b1;
                hb_cnt_r <= 5'h00;
            end else if (hb_on_r && hb_cnt_r == `CJ_HB_LEN_TICKS - 1) begin
                hb_on_r <= 1'b0;
                hb_cnt_r <= 5'h00;
            end else begin
                hb_cnt_r <= hb_cnt_r + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Transmit data path
    // ----------------------------------------
    // Drain stalls only in jabber, where writes are blocked too, so the FIFO never holds more than one sample
    sample_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .in_valid_i(tx_ok && (st_r == ST_IDLE || st_r == ST_TX)),
        .in_data_i(TX_DATA_I),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(st_r != ST_JAB)
    );

    assign any_cond = COLLISION_CMP_I || st_r == ST_JAB || hb_on_r;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            COAX_DRIVE_OUT_O <= 1'b0;
            COAX_DRIVE_EN_O <= 1'b0;
            RX_DATA_O <= 1'b0;
            RX_ACTIVE_O <= 1'b0;
            COLLISION_OUT_PAIR_P_O <= 1'b0;
            COLLISION_OUT_PAIR_N_O <= 1'b0;
            JABBER_O <= 1'b0;
        end else begin
            // Drive blocked in jabber and unjab
            COAX_DRIVE_EN_O <= fifo_out_valid && fifo_in_ready
                && (st_r == ST_IDLE || st_r == ST_TX);
            COAX_DRIVE_OUT_O <= fifo_out_valid && fifo_out_data && st_r != ST_JAB
                && st_r != ST_UNJAB;
            RX_ACTIVE_O <= RX_SQUELCH_OK_I;
            RX_DATA_O <= RX_SQUELCH_OK_I && COAX_RECEIVE_IN_I;
            // Oscillator on pair; both low is zero differential
            COLLISION_OUT_PAIR_P_O <= any_cond && osc_r;
            COLLISION_OUT_PAIR_N_O <= any_cond && !osc_r;
            JABBER_O <= (st_r == ST_JAB);
        end
    end

endmodule

`default_nettype wire

// >>> verilog/coll_jab_defines.vh
// Timing constants for the collision and jabber control block.
// Assumes a 100 MHz system clock; times are kept in their own unit.
`ifndef COLL_JAB_DEFINES_VH
`define COLL_JAB_DEFINES_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CJ_CLK_MHZ 100
`define CJ_OSC_MHZ 10
// Half period of the 10 MHz timebase in system clocks
`define CJ_OSC_HALF ((`CJ_CLK_MHZ / `CJ_OSC_MHZ) / 2)

// ----------------------------------------
// Times, counted in 10 MHz ticks (100 ns each)
// ----------------------------------------
`define CJ_HB_DELAY_NS 1100
`define CJ_HB_LEN_NS 1000
`define CJ_TX_OFF_NS 300
`define CJ_JAB_MS 20
`define CJ_UNJAB_MS 500
`define CJ_TICK_NS (1000 / `CJ_OSC_MHZ)
`define CJ_HB_DELAY_TICKS (`CJ_HB_DELAY_NS / `CJ_TICK_NS)
`define CJ_HB_LEN_TICKS (`CJ_HB_LEN_NS / `CJ_TICK_NS)
`define CJ_TX_OFF_TICKS ((`CJ_TX_OFF_NS + `CJ_TICK_NS - 1) / `CJ_TICK_NS)
`define CJ_JAB_TICKS (`CJ_JAB_MS * 1000000 / `CJ_TICK_NS)
`define CJ_UNJAB_TICKS (`CJ_UNJAB_MS * 1000000 / `CJ_TICK_NS)

// ----------------------------------------
// FIFO
// ----------------------------------------
`define CJ_FIFO_DEPTH 32

`endif

// >>> verilog/sample_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Fill side
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    // Drain side
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire do_wr;
    wire do_rd;

    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_r];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verification/collision_jabber_control_assertions.sv
// Port checker for the collision and jabber block.
// Assumes the short counts used by the bench, handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module collision_jabber_control_assertions #(
    parameter JAB_TICKS = 50
) (
    // Clock and inputs
    input wire CLK_I,
    input wire RST_N_I,
    input wire TX_SQUELCH_OK_I,
    input wire COAX_RECEIVE_IN_I,
    input wire RX_SQUELCH_OK_I,
    input wire COLLISION_CMP_I,
    input wire HEARTBEAT_GATE_N_I,
    // Outputs
    input wire COAX_DRIVE_EN_O,
    input wire RX_DATA_O,
    input wire COLLISION_OUT_PAIR_P_O,
    input wire COLLISION_OUT_PAIR_N_O,
    input wire JABBER_O
);
    wire p = COLLISION_OUT_PAIR_P_O;
    wire act = p ^ COLLISION_OUT_PAIR_N_O;
    reg [31:0] tx_r = 32'h0;
    reg [8:0] idle_r = 9'h0;
    reg [8:0] gate_r = 9'h0;
    // Run counters, idle and gate saturating, transmit wrapping; idle allows for the end timer plus a full FIFO
    always @(posedge CLK_I) begin
        tx_r <= TX_SQUELCH_OK_I ? tx_r + 32'h1 : 32'h0;
        idle_r <= TX_SQUELCH_OK_I ? 9'h0 : idle_r + {8'h0, idle_r != 9'h1ff};
        gate_r <= HEARTBEAT_GATE_N_I ? gate_r + {8'h0, gate_r != 9'h1ff} : 9'h0;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    AST_COLL_ON: assert property (COLLISION_CMP_I |=> act)
        else $error("pair idle during collision");
    AST_OSC_HALF: assert property (p [*5] |=> !p)
        else $error("half period too long");
    AST_HB_GATE: assert property (gate_r >= 9'd100 && !$past(COLLISION_CMP_I)
        && !$past(JABBER_O) && !JABBER_O |-> !act) else $error("heartbeat while gated");
    AST_JAB_EARLY: assert property ($rose(JABBER_O) |-> tx_r >= (JAB_TICKS - 2) * 10)
        else $error("jabber too early");
    AST_JAB_NODRIVE: assert property (JABBER_O |=> !COAX_DRIVE_EN_O)
        else $error("drive during jabber");
    AST_JAB_PAIR: assert property (JABBER_O && $past(JABBER_O) |-> act)
        else $error("pair idle during jabber");
    AST_TX_QUAL: assert property (idle_r > 9'd80 |-> !COAX_DRIVE_EN_O)
        else $error("drive without transmit");
    AST_RX_GATE: assert property (1'b1 |=>
        RX_DATA_O == ($past(COAX_RECEIVE_IN_I) && $past(RX_SQUELCH_OK_I)))
        else $error("receive data not gated");
endmodule
bind collision_jabber_control collision_jabber_control_assertions #(.JAB_TICKS(JAB_TICKS)) chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .TX_SQUELCH_OK_I(TX_SQUELCH_OK_I),
    .COAX_RECEIVE_IN_I(COAX_RECEIVE_IN_I), .RX_SQUELCH_OK_I(RX_SQUELCH_OK_I),
    .COLLISION_CMP_I(COLLISION_CMP_I), .HEARTBEAT_GATE_N_I(HEARTBEAT_GATE_N_I),
    .COAX_DRIVE_EN_O(COAX_DRIVE_EN_O), .RX_DATA_O(RX_DATA_O), .JABBER_O(JABBER_O),
    .COLLISION_OUT_PAIR_P_O(COLLISION_OUT_PAIR_P_O),
    .COLLISION_OUT_PAIR_N_O(COLLISION_OUT_PAIR_N_O));
`default_nettype wire

// >>> verification/terminal_model.sv
// Terminal side transmit source.
// Assumes the bench holds send low for the whole unjab wait.
`timescale 1ns/1ps
`default_nettype none
module terminal_model (
    // Clock and request
    input wire logic clk_i,
    input wire logic send_i,
    // Transmit towards the block
    output logic tx_data_o = 1'b0,
    output logic tx_ok_o = 1'b0
);
    logic [2:0] pat_r = 3'h0;
    always @(posedge clk_i) begin
        pat_r <= pat_r + 3'h1;
        tx_ok_o <= send_i;
        // Idle line keeps toggling so a stale level never looks like data
        tx_data_o <= send_i ? pat_r[1] : ~tx_data_o;
    end
endmodule
`default_nettype wire

// >>> verification/collision_jabber_control_test.sv
// Self-checking bench for the collision and jabber block.
// Short jabber and unjab counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module collision_jabber_control_test;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic send = 1'b0;
    logic rx_in = 1'b0;
    logic rx_ok = 1'b0;
    logic cmp = 1'b0;
    logic gate_n = 1'b0;
    wire tx_d, tx_ok, drv_en, dout, rx_d, rx_act, cp, cn, jab;
    int n_mismatch = 0;
    int compares = 0;
    terminal_model peer (.clk_i(CLK_I), .send_i(send), .tx_data_o(tx_d), .tx_ok_o(tx_ok));
    collision_jabber_control #(.JAB_TICKS(50), .UNJAB_TICKS(100)) uut (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .TX_DATA_I(tx_d), .TX_SQUELCH_OK_I(tx_ok),
        .COAX_RECEIVE_IN_I(rx_in), .RX_SQUELCH_OK_I(rx_ok), .COLLISION_CMP_I(cmp),
        .HEARTBEAT_GATE_N_I(gate_n), .COAX_DRIVE_OUT_O(dout), .COAX_DRIVE_EN_O(drv_en),
        .RX_DATA_O(rx_d), .RX_ACTIVE_O(rx_act), .COLLISION_OUT_PAIR_P_O(cp),
        .COLLISION_OUT_PAIR_N_O(cn), .JABBER_O(jab));
    initial begin
        forever #5 CLK_I = ~CLK_I;
    end
    task check(input logic seen, input logic want);
        compares++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %b", $time, seen);
        end
    endtask
    task complete_run;
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task t_receive;
        for (int i = 0; i < 8; i++) begin
            step(1);
            rx_in <= i[0];
            rx_ok <= i[1];
            step(1);
            #1;
            check(rx_d, i[0] & i[1]);
            check(rx_act, i[1]);
        end
    endtask
    task t_collision;
        int rises;
        logic prev;
        step(1);
        cmp <= 1'b1;
        step(3);
        #1;
        check(cp ^ cn, 1'b1);
        rises = 0;
        prev = cp;
        repeat (100) begin
            step(1);
            #1;
            if (cp && !prev) rises++;
            prev = cp;
        end
        check(rises == 10, 1'b1);
        step(1);
        cmp <= 1'b0;
        step(3);
        #1;
        check(cp | cn, 1'b0);
    endtask
    task t_frame(input logic off);
        int t0;
        int len;
        logic [1:0] hist;
        step(1);
        gate_n <= off;
        send <= 1'b1;
        hist = 2'h0;
        for (int i = 0; i < 200; i++) begin
            step(1);
            #1;
            // Coax data trails the terminal by two clocks through the FIFO
            if (i > 8) check(dout, hist[1]);
            hist = {hist[0], tx_d};
        end
        check(drv_en, 1'b1);
        step(1);
        send <= 1'b0;
        t0 = -1;
        len = 0;
        for (int i = 0; i < 400; i++) begin
            step(1);
            #1;
            if ((cp ^ cn) === 1'b1) begin
                if (t0 < 0) t0 = i;
                len++;
            end
        end
        if (off) begin
            check(len == 0, 1'b1);
        end else begin
            check(t0 >= 120 && t0 <= 180 && len >= 90 && len <= 110, 1'b1);
        end
    endtask
    task t_jabber;
        int n;
        step(1);
        send <= 1'b1;
        n = 0;
        while (jab !== 1'b1 && n < 1000) begin
            step(1);
            #1;
            n++;
        end
        check(n >= 495 && n <= 540, 1'b1);
        step(2);
        #1;
        check(drv_en, 1'b0);
        check(cp ^ cn, 1'b1);
        step(1);
        send <= 1'b0;
        step(3);
        #1;
        check(jab, 1'b0);
        repeat (950) begin
            step(1);
            #1;
            check(drv_en, 1'b0);
            check(cp | cn, 1'b0);
        end
        step(150);
        send <= 1'b1;
        step(6);
        #1;
        check(drv_en, 1'b1);
        step(1);
        send <= 1'b0;
        step(300);
    endtask
    initial begin
        repeat (20) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        step(1);
        #1;
        check(drv_en | jab | cp | cn, 1'b0);
        t_receive;
        t_collision;
        t_frame(1'b0);
        t_frame(1'b1);
        t_jabber;
        complete_run;
    end
    initial begin
        #100000;
        n_mismatch++;
        complete_run;
    end
endmodule
`default_nettype wire
